//--- rtl/pid_process_controller.sv
// Sampled recursive PID controller that produces a motor speed reference.
module pid_process_controller #(
  parameter int CYCLES_PER_MS = pid_pkg::CYCLES_PER_MS,
  parameter logic [15:0] APP_VERSION = 16'h0064
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] proportional_gain_i,
  input wire logic [15:0] integral_gain_i,
  input wire logic [15:0] derivative_gain_i,
  input wire logic [15:0] sample_period_i,
  input wire logic [15:0] min_motor_speed_i,
  input wire logic [15:0] max_motor_speed_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic reverse_action_i,
  input wire logic [1:0] app_command_i,
  input wire logic app_fault_i,
  input wire logic auto_setpoint_we_i,
  input wire logic signed [15:0] auto_setpoint_i,
  input wire logic [3:0] stored_setpoint_we_i,
  input wire logic signed [15:0] stored_setpoint_i,
  input wire logic manual_setpoint_we_i,
  input wire logic [15:0] manual_setpoint_i,
  input wire logic [3:0] setpoint_source_sel_i,
  input wire logic [3:0] setpoint_mode_sel_i,
  input wire logic [1:0] pv_source_sel_i,
  input wire logic signed [15:0] pv_scale_min_i,
  input wire logic signed [15:0] pv_scale_max_i,
  input wire logic [15:0] analog_input_one_i,
  input wire logic [15:0] analog_input_two_i,
  input wire logic manual_auto_input_i,
  input wire logic setpoint_sel_input_a_i,
  input wire logic setpoint_sel_input_b_i,
  output logic [2:0] app_state_o,
  output logic [15:0] app_version_o,
  output logic signed [15:0] auto_setpoint_o,
  output logic signed [15:0] process_value_o,
  output logic [15:0] controller_output_o,
  output logic [15:0] manual_setpoint_o,
  output logic [15:0] controller_status_word_o,
  output logic [15:0] speed_reference_o,
  output logic sample_strobe_o
);

  if (CYCLES_PER_MS < 1)
  begin : g_bad_rate
    $error("CYCLES_PER_MS must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Application run state and sample timing.

  logic running;
  logic [31:0] ms_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic sample_tick;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      app_state_o <= pid_pkg::STATE_STOPPED;
    end
    else if (app_fault_i)
    begin
      app_state_o <= 3'h0;
    end
    else if (app_state_o == pid_pkg::STATE_STOPPED && app_command_i == pid_pkg::CMD_RUN)
    begin
      app_state_o <= pid_pkg::STATE_RUNNING;
    end
    else if (app_state_o == 3'h0)
    begin
      app_state_o <= pid_pkg::STATE_STOPPED;
    end
  end

  assign running = (app_state_o == pid_pkg::STATE_RUNNING);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || !running)
    begin
      ms_cnt_reg <= 32'h0000_0000;
      period_cnt_reg <= 16'h0000;
    end
    else if (ms_cnt_reg == 32'(CYCLES_PER_MS - 1))
    begin
      ms_cnt_reg <= 32'h0000_0000;
      if (period_cnt_reg + 16'h0001 >= sample_period_i)
      begin
        period_cnt_reg <= 16'h0000;
      end
      else
      begin
        period_cnt_reg <= period_cnt_reg + 16'h0001;
      end
    end
    else
    begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end

  assign sample_tick = running && (ms_cnt_reg == 32'(CYCLES_PER_MS - 1))
                       && (period_cnt_reg + 16'h0001 >= sample_period_i);

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint storage and selection.

  logic signed [15:0] bank_reg [4];
  logic signed [15:0] panel_sp_reg;
  logic signed [15:0] active_sp;
  logic bank_mode;

  function automatic logic signed [15:0] clip_val(input logic signed [15:0] v);
    if (v > pid_pkg::VAL_MAX)
      clip_val = pid_pkg::VAL_MAX;
    else if (v < pid_pkg::VAL_MIN)
      clip_val = pid_pkg::VAL_MIN;
    else
      clip_val = v;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      localparam logic signed [15:0] RST = (gi == 0) ? pid_pkg::SP1_RST :
        (gi == 1) ? pid_pkg::SP2_RST : (gi == 2) ? pid_pkg::SP3_RST : pid_pkg::SP4_RST;
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
          bank_reg[gi] <= RST;
        else if (stored_setpoint_we_i[gi])
          bank_reg[gi] <= clip_val(stored_setpoint_i);
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      panel_sp_reg <= pid_pkg::SP_AUTO_RST;
    else if (auto_setpoint_we_i)
      panel_sp_reg <= clip_val(auto_setpoint_i);
  end

  assign bank_mode = setpoint_mode_sel_i >= pid_pkg::SP_MODE_BANK_LO
                     && setpoint_mode_sel_i <= pid_pkg::SP_MODE_BANK_HI;

  always_comb
  begin
    if (setpoint_source_sel_i != pid_pkg::SP_SRC_PANEL && bank_mode)
      active_sp = bank_reg[{setpoint_sel_input_b_i, setpoint_sel_input_a_i}];
    else
      active_sp = panel_sp_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      auto_setpoint_o <= pid_pkg::SP_AUTO_RST;
    else
      auto_setpoint_o <= active_sp;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      manual_setpoint_o <= pid_pkg::MAN_RST;
    else if (manual_setpoint_we_i)
      manual_setpoint_o <= (manual_setpoint_i > pid_pkg::MAN_MAX) ? pid_pkg::MAN_MAX
                                                                  : manual_setpoint_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process value scaling (analog fraction is Q16: 16'hffff is full scale).

  logic [15:0] ai_sel;
  logic signed [33:0] pv_wide;

  assign ai_sel = (pv_source_sel_i == 2'h2) ? analog_input_two_i : analog_input_one_i;
  assign pv_wide = (34'(signed'({1'b0, ai_sel})) * 34'(pv_scale_max_i - pv_scale_min_i))
                   >>> 16;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      process_value_o <= 16'sh0000;
    else
      process_value_o <= clip_val(16'(pv_wide) + pv_scale_min_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recursive PID step.

  logic signed [15:0] err;
  logic signed [15:0] prev_err_reg;
  logic signed [15:0] integ_reg;
  logic signed [63:0] term_cur;
  logic signed [63:0] term_prev;
  logic signed [63:0] kp_w;
  logic signed [63:0] ki_w;
  logic signed [63:0] kd_w;
  logic signed [63:0] ta_w;
  logic signed [63:0] d_w;
  logic [31:0] man_pct;
  logic [15:0] man_out;
  logic signed [63:0] y_wide;
  logic [15:0] y_clip;
  logic auto_mode;
  logic at_min_speed;

  assign auto_mode = manual_auto_input_i;
  assign err = reverse_action_i ? (process_value_o - auto_setpoint_o)
                                : (auto_setpoint_o - process_value_o);
  assign at_min_speed = motor_speed_i >= min_motor_speed_i;

  // Gains are held signed so that a negative error survives the final division.
  assign kp_w = 64'(proportional_gain_i);
  assign ki_w = 64'(integral_gain_i);
  assign kd_w = 64'(derivative_gain_i);
  // A zero period runs as one millisecond, as the sample timer does.
  assign ta_w = (sample_period_i == 16'h0000) ? 64'sd1 : 64'(sample_period_i);
  assign d_w = kd_w * 64'(pid_pkg::PERIOD_SCALE * pid_pkg::PERIOD_SCALE) / ta_w;

  always_comb
  begin
    term_cur = 64'(err) * (64'(pid_pkg::GAIN_SCALE * pid_pkg::PERIOD_SCALE) + ki_w * ta_w + d_w);
    term_prev = 64'(prev_err_reg) * d_w;
    y_wide = 64'(integ_reg) + kp_w * (term_cur - term_prev) * 64'sd10
             / 64'(pid_pkg::GAIN_SCALE * pid_pkg::GAIN_SCALE * pid_pkg::PERIOD_SCALE);
    if (y_wide < 64'sh0)
      y_clip = 16'h0000;
    else if (y_wide > 64'(pid_pkg::OUT_MAX))
      y_clip = pid_pkg::OUT_MAX;
    else
      y_clip = 16'(y_wide);
  end

  always_comb
  begin
    man_pct = 32'h0000_0000;
    if (max_motor_speed_i > min_motor_speed_i && manual_setpoint_o > min_motor_speed_i)
    begin
      man_pct = (32'(manual_setpoint_o - min_motor_speed_i) * 32'(pid_pkg::OUT_MAX))
                / 32'(max_motor_speed_i - min_motor_speed_i);
    end
    // A manual setpoint above top speed would otherwise push the output past full scale.
    man_out = (man_pct > 32'(pid_pkg::OUT_MAX)) ? pid_pkg::OUT_MAX : man_pct[15:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      integ_reg <= 16'sh0000;
      prev_err_reg <= 16'sh0000;
      controller_output_o <= 16'h0000;
    end
    else if (!auto_mode)
    begin
      controller_output_o <= man_out;
      integ_reg <= 16'(controller_output_o);
      prev_err_reg <= err;
    end
    else if (sample_tick && at_min_speed)
    begin
      integ_reg <= 16'(y_clip);
      controller_output_o <= y_clip;
      prev_err_reg <= err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed reference, status and identity.

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      speed_reference_o <= 16'h0000;
    else if (!auto_mode)
      speed_reference_o <= manual_setpoint_o;
    else if (!at_min_speed)
      speed_reference_o <= min_motor_speed_i;
    else
      speed_reference_o <= min_motor_speed_i + 16'((32'(controller_output_o)
        * 32'(max_motor_speed_i - min_motor_speed_i)) / 32'(pid_pkg::OUT_MAX));
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      controller_status_word_o <= 16'h0000;
    else
      controller_status_word_o <= 16'(auto_mode) << pid_pkg::STATUS_AUTO_BIT;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      sample_strobe_o <= 1'b0;
    else
      sample_strobe_o <= sample_tick;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      app_version_o <= 16'h0000;
    else
      app_version_o <= (APP_VERSION > 16'h2328) ? 16'h2328 : APP_VERSION;
  end

endmodule

//--- rtl/pid_pkg.sv
// Constants, encodings and reset values for the sampled process controller.
package pid_pkg;
  // Engineering values are hundredths; output in tenths of percent; speed in tenths of Hz.
  localparam int VAL_W = 16;
  localparam logic signed [15:0] VAL_MAX = 16'sh270f;
  localparam logic signed [15:0] VAL_MIN = -16'sh270f;
  localparam logic [15:0] OUT_MAX = 16'h03e8;
  localparam logic [15:0] MAN_MAX = 16'h0fa0;
  localparam logic signed [15:0] SP_AUTO_RST = 16'sh00c8;
  localparam logic signed [15:0] SP1_RST = 16'sh00c8;
  localparam logic signed [15:0] SP2_RST = 16'sh00e6;
  localparam logic signed [15:0] SP3_RST = 16'sh00b4;
  localparam logic signed [15:0] SP4_RST = 16'sh00a0;
  localparam logic [15:0] MAN_RST = 16'h0000;
  localparam logic [2:0] STATE_STOPPED = 3'h3;
  localparam logic [2:0] STATE_RUNNING = 3'h4;
  localparam logic [1:0] CMD_RUN = 2'h1;
  localparam logic [3:0] SP_SRC_PANEL = 4'h0;
  localparam logic [3:0] SP_MODE_BANK_LO = 4'h4;
  localparam logic [3:0] SP_MODE_BANK_HI = 4'h6;
  localparam int STATUS_AUTO_BIT = 1;
  // Gains in hundredths; period in milliseconds.
  localparam int GAIN_SCALE = 100;
  localparam int PERIOD_SCALE = 1000;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
endpackage

//--- tb/pid_process_controller_monitor.sv
// Port assertions for the process controller.
module pid_process_controller_monitor #(
  parameter logic [15:0] APP_VERSION = 16'h0064
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] app_command_i,
  input wire logic app_fault_i,
  input wire logic manual_auto_input_i,
  input wire logic [2:0] app_state_o,
  input wire logic [15:0] app_version_o,
  input wire logic signed [15:0] process_value_o,
  input wire logic [15:0] controller_output_o,
  input wire logic [15:0] controller_status_word_o,
  input wire logic sample_strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////
  property p_lim; controller_output_o <= pid_pkg::OUT_MAX; endproperty
  a_lim: assert property (p_lim) else $error("output over range");
  property p_pv; process_value_o >= pid_pkg::VAL_MIN && process_value_o <= pid_pkg::VAL_MAX;
  endproperty
  a_pv: assert property (p_pv) else $error("process value out of span");
  property p_run; app_state_o == 3'h3 && app_command_i == 2'h1 && !app_fault_i
    |=> app_state_o == 3'h4; endproperty
  a_run: assert property (p_run) else $error("start command ignored");
  property p_keep; app_state_o == 3'h4 && !app_fault_i |=> app_state_o == 3'h4; endproperty
  a_keep: assert property (p_keep) else $error("running state lost");
  property p_flt; app_fault_i |=> app_state_o == 3'h0; endproperty
  a_flt: assert property (p_flt) else $error("fault state not shown");
  property p_ver; $past(reset_n_i) |-> app_version_o == APP_VERSION; endproperty
  a_ver: assert property (p_ver) else $error("version wrong");
  property p_sts; ($past(reset_n_i) && $stable(manual_auto_input_i)) [*3]
    |-> controller_status_word_o == {14'h0000, manual_auto_input_i, 1'b0}; endproperty
  a_sts: assert property (p_sts) else $error("status word wrong");
  property p_stb; sample_strobe_o |=> !sample_strobe_o; endproperty
  a_stb: assert property (p_stb) else $error("strobe too long");
  c_run: cover property (app_state_o == 3'h4 && sample_strobe_o);
  c_sat: cover property (controller_output_o == pid_pkg::OUT_MAX);
  c_man: cover property (!manual_auto_input_i && app_state_o == 3'h4);
endmodule
bind pid_process_controller pid_process_controller_monitor #(.APP_VERSION(APP_VERSION)) mon_i (.*);

//--- tb/process_plant_model.sv
// Drive speed loop and process sensor on the controller's far side.
module process_plant_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] speed_reference_i,
  output logic [15:0] motor_speed_o,
  output logic [15:0] analog_input_one_o,
  output logic [15:0] analog_input_two_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stalled shaft never reaches minimum speed, so regulation must wait.
  always_ff @(posedge clk_i) motor_speed_o <= stall_i ? 16'h0000 : speed_reference_i;
  assign analog_input_one_o = level_i;
  // The second sensor reads half, so a source swap is visible.
  assign analog_input_two_o = {1'b0, level_i[15:1]};
endmodule

//--- tb/pid_process_controller_test.sv
// Self-checking bench for the sampled process controller.
module pid_process_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, reset_n_i, stall, reverse_action_i, app_fault_i, auto_setpoint_we_i;
  logic manual_setpoint_we_i, manual_auto_input_i, setpoint_sel_input_a_i;
  logic setpoint_sel_input_b_i, sample_strobe_o;
  logic [1:0] app_command_i, pv_source_sel_i;
  logic [2:0] app_state_o;
  logic [3:0] stored_setpoint_we_i, setpoint_source_sel_i, setpoint_mode_sel_i;
  logic [15:0] proportional_gain_i, integral_gain_i, derivative_gain_i, sample_period_i;
  logic [15:0] min_motor_speed_i, max_motor_speed_i, motor_speed_i, auto_setpoint_i;
  logic [15:0] stored_setpoint_i, manual_setpoint_i, pv_scale_min_i, pv_scale_max_i;
  logic [15:0] analog_input_one_i, analog_input_two_i, level, app_version_o;
  logic [15:0] auto_setpoint_o, process_value_o, controller_output_o, manual_setpoint_o;
  logic [15:0] controller_status_word_o, speed_reference_o;
  logic [15:0] bank [4] = '{16'h00c8, 16'h00e6, 16'h00b4, 16'h00a0};
  int bad_count = 0, n_checks = 0;
  int n_strobe = 0, strobe_mark = 0;
  always #50 clk_i = ~clk_i;
  // Strobes are counted at the edge, before the design moves them.
  always @(posedge clk_i)
    if (sample_strobe_o === 1'b1)
      n_strobe++;
  pid_process_controller #(.CYCLES_PER_MS(2), .APP_VERSION(16'h0123)) pid_process_controller_i (.*);
  process_plant_model process_plant_model_i (.clk_i, .stall_i(stall), .level_i(level),
    .speed_reference_i(speed_reference_o), .motor_speed_o(motor_speed_i),
    .analog_input_one_o(analog_input_one_i), .analog_input_two_o(analog_input_two_i));
  ////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic until_out(input logic [15:0] v);
    for (int i = 0; i < 3000 && controller_output_o !== v; i++) wt(1);
    chk(controller_output_o, v);
  endtask
  // Panel, manual and bank-entry-four writes share one pulse sequence.
  task automatic wr(input int k, input logic [15:0] v);
    @(posedge clk_i);
    {auto_setpoint_i, manual_setpoint_i, stored_setpoint_i} <= {3{v}};
    {auto_setpoint_we_i, manual_setpoint_we_i} <= {k == 0, k == 1};
    stored_setpoint_we_i <= (k == 2) ? 4'h8 : 4'h0;
    @(posedge clk_i);
    {auto_setpoint_we_i, manual_setpoint_we_i, stored_setpoint_we_i} <= 6'h00;
    wt(3);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////
  initial
  begin
    {reset_n_i, stall, reverse_action_i, app_fault_i, auto_setpoint_we_i} = 5'h00;
    {manual_setpoint_we_i, manual_auto_input_i, setpoint_sel_input_a_i} = 3'h0;
    {setpoint_sel_input_b_i, app_command_i, stored_setpoint_we_i} = 7'h00;
    {setpoint_source_sel_i, setpoint_mode_sel_i, pv_source_sel_i} = 10'h001;
    {integral_gain_i, derivative_gain_i, auto_setpoint_i, stored_setpoint_i} = '0;
    {manual_setpoint_i, pv_scale_min_i, pv_scale_max_i, level} = 64'h0000_ff9c_012c_8000;
    {proportional_gain_i, sample_period_i, min_motor_speed_i, max_motor_speed_i} =
      64'h0064_0001_0190_0258;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wt(4);
    chk(16'(app_state_o), 16'h0003);
    chk(auto_setpoint_o, 16'h00c8);
    chk(process_value_o, 16'h0064);
    chk(app_version_o, 16'h0123);
    chk(controller_status_word_o, 16'h0000);
    @(posedge clk_i);
    pv_source_sel_i <= 2'h2;
    wt(4);
    chk(process_value_o, 16'h0000);
    @(posedge clk_i);
    setpoint_source_sel_i <= 4'h1;
    for (int m = 4; m < 7; m++)
      for (int i = 0; i < 4; i++)
      begin
        @(posedge clk_i);
        setpoint_mode_sel_i <= 4'(m);
        {setpoint_sel_input_b_i, setpoint_sel_input_a_i} <= 2'(i);
        wt(4);
        chk(auto_setpoint_o, bank[i]);
      end
    wr(2, 16'hff00);
    chk(auto_setpoint_o, 16'hff00);
    @(posedge clk_i);
    setpoint_source_sel_i <= 4'h0;
    wr(0, 16'h2710);
    chk(auto_setpoint_o, 16'h270f);
    @(posedge clk_i);
    {app_command_i, manual_auto_input_i, stall} <= 4'h7;
    wt(1);
    chk(16'(app_state_o), 16'h0004);
    chk(controller_status_word_o, 16'h0002);
    wt(8);
    strobe_mark = n_strobe;
    wt(32);
    chk(16'(n_strobe - strobe_mark), 16'h0010);
    chk(controller_output_o, 16'h0000);
    @(posedge clk_i);
    stall <= 1'b0;
    until_out(16'h03e8);
    wt(3);
    chk(speed_reference_o, 16'h0258);
    @(posedge clk_i);
    reverse_action_i <= 1'b1;
    until_out(16'h0000);
    wt(3);
    chk(speed_reference_o, 16'h0190);
    @(posedge clk_i);
    manual_auto_input_i <= 1'b0;
    wr(1, 16'h01f4);
    chk(speed_reference_o, 16'h01f4);
    chk(controller_output_o, 16'h01f4);
    chk(controller_status_word_o, 16'h0000);
    wr(1, 16'h1388);
    chk(manual_setpoint_o, 16'h0fa0);
    chk(controller_output_o, 16'h03e8);
    @(posedge clk_i);
    app_fault_i <= 1'b1;
    wt(2);
    chk(16'(app_state_o), 16'h0000);
    final_report;
  end
  initial
  begin
    #2_000_000;
    bad_count++;
    final_report;
  end
endmodule
